// file: hdl/obd_consts.vh
// Offsets, field positions, reset values and timing counts of the option byte decoder
`ifndef OBD_CONSTS_VH
`define OBD_CONSTS_VH

// Register byte offsets
`define OBD_ADDR_OPT 4'h0
`define OBD_ADDR_CMD 4'h4
`define OBD_ADDR_STAT 4'h8
`define OBD_ADDR_CFG 4'hc

// Command and status bit positions
`define OBD_CMD_ERASE 0
`define OBD_STAT_BUSY 0
`define OBD_STAT_PROT 1
`define OBD_STAT_PROG 2
`define OBD_STAT_LOADED 3

// Option byte 0 fields
`define OBD_B0_HALT 7
`define OBD_B0_WDG 6
`define OBD_B0_VD_HI 4
`define OBD_B0_VD_LO 3
`define OBD_B0_PROT 0

// Option byte 1 fields
`define OBD_B1_PKG 7
`define OBD_B1_RESET_LENGTH_SEL 6
`define OBD_B1_OSC_HI 5
`define OBD_B1_OSC_LO 4
`define OBD_B1_RNG_HI 3
`define OBD_B1_RNG_LO 1
`define OBD_B1_PLL 0

// Erased flash content
`define OBD_ERASED 8'hff

// Voltage detect and clock source codes
`define OBD_VD_OFF 2'h3
`define OBD_OSC_RES 2'h0
`define OBD_OSC_RSVD 2'h1
`define OBD_OSC_RC 2'h2
`define OBD_OSC_EXT 2'h3

// Decoded configuration bundle
`define OBD_CFG_W 19
`define OBD_CF_HALT 0
`define OBD_CF_WDG_HW 1
`define OBD_CF_LVD 2
`define OBD_CF_AVD 3
`define OBD_CF_THR_LO 4
`define OBD_CF_THR_HI 5
`define OBD_CF_PROT 6
`define OBD_CF_PKG 7
`define OBD_CF_PULLUP 8
`define OBD_CF_RST_LONG 9
`define OBD_CF_RES 10
`define OBD_CF_RC 11
`define OBD_CF_EXT 12
`define OBD_CF_RSVD 13
`define OBD_CF_RNG_LO 14
`define OBD_CF_RNG_HI 16
`define OBD_CF_CUR 17
`define OBD_CF_PLL 18
`define OBD_CFG_RST 19'h1d0b1

// Reset phase lengths in CPU cycles
`define OBD_RST_LONG 13'h1000
`define OBD_RST_SHORT 13'h0100

`endif

// file: hdl/obd_cfg_hold.v
// Static configuration hold register, loaded once after reset
module obd_cfg_hold #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Load strobe and data
  input wire load,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else if (load) begin
      q <= d;
    end
  end

endmodule

// file: hdl/obd_option_decoder.v
// Option byte store, AHB-Lite access and static configuration decoder
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`include "obd_consts.vh"

module obd_option_decoder #(
  parameter MASK_ROM = 0
) (
  // Clock and resets
  input wire hclk,
  input wire hresetn,
  input wire por_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Device straps and programming mode
  input wire prog_mode,
  input wire part_64pin,
  // User memory erase handshake
  output wire user_mem_erase_req,
  input wire user_mem_erase_done,
  // Watchdog and reset sequencer
  output wire halt_entry_reset_en,
  output wire watchdog_hw_en,
  output wire [12:0] reset_len_cycles,
  // Voltage detectors
  output wire low_supply_detector_en,
  output wire auxiliary_supply_detector_en,
  output wire [1:0] voltage_detect_sel,
  // Flash protection
  output wire readout_protect_en,
  output wire flash_write_block,
  // Package and pads
  output wire package_sel_hi,
  output wire unbonded_pad_pullup,
  // Oscillator and doubler
  output wire osc_resonator_sel,
  output wire osc_rc_sel,
  output wire osc_external_sel,
  output wire osc_reserved_sel,
  output wire [2:0] osc_freq_range_sel,
  output wire osc_range_is_current,
  output wire clock_doubler_en
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MEM_ERASE = 3'b010;
  localparam [2:0] ST_OPT_ERASE = 3'b100;

  reg [7:0] opt0_reg;
  reg [7:0] opt1_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg loaded_reg;
  reg dph_write_reg;
  reg dph_word_reg;
  reg [3:0] dph_addr_reg;
  reg [31:0] rdata_next;
  reg [`OBD_CFG_W-1:0] cfg_next;
  wire [`OBD_CFG_W-1:0] cfg;
  wire addr_phase;
  wire busy;
  wire store_protected;
  wire dph_opt_hit;
  wire dph_cmd_hit;
  wire opt_write;
  wire erase_cmd;
  wire [1:0] vd_code;
  wire [1:0] osc_code;

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign addr_phase = hsel & htrans[1] & hready;
  assign busy = (state_reg != ST_IDLE);

  // Mask parts keep the protection bit with the opposite sense
  generate
    if (MASK_ROM != 0) begin : g_mask_sense
      assign store_protected = opt0_reg[`OBD_B0_PROT];
    end else begin : g_flash_sense
      assign store_protected = ~opt0_reg[`OBD_B0_PROT];
    end
  endgenerate

  // Only whole-word writes reach the store and the command
  assign dph_opt_hit = dph_write_reg & dph_word_reg & (dph_addr_reg == `OBD_ADDR_OPT);
  assign dph_cmd_hit = dph_write_reg & dph_word_reg & (dph_addr_reg == `OBD_ADDR_CMD);

  // Option bytes only reachable in programming mode
  assign opt_write = dph_opt_hit & prog_mode & ~busy;
  assign erase_cmd = dph_cmd_hit & prog_mode & hwdata[`OBD_CMD_ERASE] & ~busy;

  // Data phase tracking
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_write_reg <= 1'b0;
      dph_word_reg <= 1'b0;
      dph_addr_reg <= 4'h0;
    end else if (hready) begin
      dph_write_reg <= addr_phase & hwrite;
      dph_word_reg <= (hsize == 3'h2);
      dph_addr_reg <= haddr[3:0];
    end
  end

  // Read data captured in the address phase so hrdata comes from a flop
  always @* begin
    rdata_next = 32'h0000_0000;
    case (haddr[3:0])
      `OBD_ADDR_OPT: begin
        if (prog_mode) begin
          rdata_next = {16'h0000, opt1_reg, opt0_reg};
        end
      end
      `OBD_ADDR_STAT: begin
        rdata_next[`OBD_STAT_BUSY] = busy;
        rdata_next[`OBD_STAT_PROT] = store_protected;
        rdata_next[`OBD_STAT_PROG] = prog_mode;
        rdata_next[`OBD_STAT_LOADED] = loaded_reg;
      end
      `OBD_ADDR_CFG: begin
        rdata_next = {13'h0000, cfg};
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // Erase sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (erase_cmd) begin
          if (store_protected) begin
            state_next = ST_MEM_ERASE;
          end else begin
            state_next = ST_OPT_ERASE;
          end
        end
      end
      ST_MEM_ERASE: begin
        if (user_mem_erase_done) begin
          state_next = ST_OPT_ERASE;
        end
      end
      ST_OPT_ERASE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign user_mem_erase_req = (state_reg == ST_MEM_ERASE);

  // Non-volatile store: survives hresetn, only power-on or the option erase state sets it to erased
  always @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      opt0_reg <= `OBD_ERASED;
      opt1_reg <= `OBD_ERASED;
    end else if (state_reg == ST_OPT_ERASE) begin
      opt0_reg <= `OBD_ERASED;
      opt1_reg <= `OBD_ERASED;
    end else if (opt_write) begin
      // Flash programming can only clear bits
      opt0_reg <= opt0_reg & hwdata[7:0];
      opt1_reg <= opt1_reg & hwdata[15:8];
    end
  end

  // One load in the first cycle after reset release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
    end
  end

  assign vd_code = opt0_reg[`OBD_B0_VD_HI:`OBD_B0_VD_LO];
  assign osc_code = opt1_reg[`OBD_B1_OSC_HI:`OBD_B1_OSC_LO];

  // Decode; byte0 bits 5, 2 and 1 are not looked at
  always @* begin
    cfg_next = {`OBD_CFG_W{1'b0}};
    cfg_next[`OBD_CF_HALT] = opt0_reg[`OBD_B0_HALT];
    cfg_next[`OBD_CF_WDG_HW] = ~opt0_reg[`OBD_B0_WDG];
    // Both detectors share one threshold; only code 11 turns them off
    case (vd_code)
      `OBD_VD_OFF: begin
        cfg_next[`OBD_CF_LVD] = 1'b0;
        cfg_next[`OBD_CF_AVD] = 1'b0;
      end
      default: begin
        cfg_next[`OBD_CF_LVD] = 1'b1;
        cfg_next[`OBD_CF_AVD] = 1'b1;
      end
    endcase
    cfg_next[`OBD_CF_THR_HI:`OBD_CF_THR_LO] = vd_code;
    cfg_next[`OBD_CF_PROT] = store_protected;
    cfg_next[`OBD_CF_PKG] = opt1_reg[`OBD_B1_PKG];
    // Large part: 44-pin bonding leaves pads open; small part never bonds all
    cfg_next[`OBD_CF_PULLUP] = part_64pin ? ~opt1_reg[`OBD_B1_PKG] : 1'b1;
    cfg_next[`OBD_CF_RST_LONG] = ~opt1_reg[`OBD_B1_RESET_LENGTH_SEL];
    cfg_next[`OBD_CF_RNG_HI:`OBD_CF_RNG_LO] = opt1_reg[`OBD_B1_RNG_HI:`OBD_B1_RNG_LO];
    // Range steers the current source only behind a resonator
    case (osc_code)
      `OBD_OSC_RES: begin
        cfg_next[`OBD_CF_RES] = 1'b1;
        cfg_next[`OBD_CF_CUR] = 1'b1;
      end
      `OBD_OSC_RC: begin
        cfg_next[`OBD_CF_RC] = 1'b1;
      end
      `OBD_OSC_EXT: begin
        cfg_next[`OBD_CF_EXT] = 1'b1;
      end
      default: begin
        cfg_next[`OBD_CF_RSVD] = 1'b1;
      end
    endcase
    cfg_next[`OBD_CF_PLL] = ~opt1_reg[`OBD_B1_PLL];
  end

  // Held static until next reset, software writes never reach it
  obd_cfg_hold #(
    .W(`OBD_CFG_W),
    .RST(`OBD_CFG_RST)
  ) u_cfg_hold (
    .clk(hclk),
    .rst_n(hresetn),
    .load(~loaded_reg),
    .d(cfg_next),
    .q(cfg)
  );

  // Watchdog and reset sequencer
  assign halt_entry_reset_en = cfg[`OBD_CF_HALT];
  assign watchdog_hw_en = cfg[`OBD_CF_WDG_HW];
  assign reset_len_cycles = cfg[`OBD_CF_RST_LONG] ? `OBD_RST_LONG : `OBD_RST_SHORT;
  // Voltage detectors
  assign low_supply_detector_en = cfg[`OBD_CF_LVD];
  assign auxiliary_supply_detector_en = cfg[`OBD_CF_AVD];
  assign voltage_detect_sel = cfg[`OBD_CF_THR_HI:`OBD_CF_THR_LO];
  // Flash protection, package and pads
  assign readout_protect_en = cfg[`OBD_CF_PROT];
  assign flash_write_block = cfg[`OBD_CF_PROT];
  assign package_sel_hi = cfg[`OBD_CF_PKG];
  assign unbonded_pad_pullup = cfg[`OBD_CF_PULLUP];
  // Oscillator and doubler
  assign osc_resonator_sel = cfg[`OBD_CF_RES];
  assign osc_rc_sel = cfg[`OBD_CF_RC];
  assign osc_external_sel = cfg[`OBD_CF_EXT];
  assign osc_reserved_sel = cfg[`OBD_CF_RSVD];
  assign osc_freq_range_sel = cfg[`OBD_CF_RNG_HI:`OBD_CF_RNG_LO];
  assign osc_range_is_current = cfg[`OBD_CF_CUR];
  assign clock_doubler_en = cfg[`OBD_CF_PLL];

endmodule

// file: sim/obd_option_decoder_props.sv
// Concurrent checks on the option byte decoder ports
module obd_option_decoder_props (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus answer
  input wire hreadyout,
  input wire hresp,
  // Erase handshake
  input wire user_mem_erase_req,
  input wire user_mem_erase_done,
  // Decoded configuration
  input wire [12:0] reset_len_cycles,
  input wire low_supply_detector_en,
  input wire auxiliary_supply_detector_en,
  input wire [1:0] voltage_detect_sel,
  input wire readout_protect_en,
  input wire flash_write_block,
  input wire osc_resonator_sel,
  input wire osc_rc_sel,
  input wire osc_external_sel,
  input wire osc_reserved_sel,
  input wire osc_range_is_current
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_erase_wait;
    user_mem_erase_req && !user_mem_erase_done;
  endsequence
  sequence s_erase_ack;
    user_mem_erase_req && user_mem_erase_done;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_detect_pair: assert property ((low_supply_detector_en == (voltage_detect_sel != 2'h3))
    && (auxiliary_supply_detector_en == low_supply_detector_en))
    else $error("detector enables disagree with threshold code");
  a_protect_block: assert property (flash_write_block == readout_protect_en)
    else $error("write block differs from protection");
  a_osc_onehot: assert property ($onehot({osc_resonator_sel, osc_rc_sel,
    osc_external_sel, osc_reserved_sel}))
    else $error("clock source select not one-hot");
  a_range_mode: assert property (osc_range_is_current == osc_resonator_sel)
    else $error("range meaning wrong for clock source");
  a_reset_len: assert property ((reset_len_cycles == 13'h1000) ||
    (reset_len_cycles == 13'h0100))
    else $error("reset length not 4096 or 256");
  // Two cycles of grace: the load edge follows the release edge
  a_cfg_static: assert property ($past(hresetn, 2) |-> $stable({reset_len_cycles,
    voltage_detect_sel, readout_protect_en, osc_range_is_current, osc_external_sel}))
    else $error("configuration changed without reset");
  a_erase_hold: assert property (s_erase_wait |=> user_mem_erase_req)
    else $error("erase request dropped before done");
  a_erase_release: assert property (s_erase_ack |=> !user_mem_erase_req)
    else $error("erase request held after done");
endmodule
bind obd_option_decoder obd_option_decoder_props i_props (.hclk, .hresetn, .hreadyout, .hresp,
  .user_mem_erase_req, .user_mem_erase_done, .reset_len_cycles, .low_supply_detector_en,
  .auxiliary_supply_detector_en, .voltage_detect_sel, .readout_protect_en, .flash_write_block,
  .osc_resonator_sel, .osc_rc_sel, .osc_external_sel, .osc_reserved_sel, .osc_range_is_current);

// file: sim/obd_mem_eraser.sv
// Behavioural user memory eraser answering the erase request
module obd_mem_eraser (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Erase handshake and answer delay
  input wire req,
  input wire [7:0] dly,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  // One-cycle done pulse; a held done could start a second erase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      done <= 1'b0;
    end else if (req && !done && cnt_reg >= dly) begin
      cnt_reg <= 8'h00;
      done <= 1'b1;
    end else begin
      cnt_reg <= (req && !done) ? cnt_reg + 8'h01 : 8'h00;
      done <= 1'b0;
    end
  end
endmodule

// file: sim/obd_option_decoder_tb.sv
// Self-checking bench for the option byte decoder
`include "obd_consts.vh"
module obd_option_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, por_n = 0, hsel = 0, hwrite = 0, prog_mode = 0, part_64pin = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [7:0] erase_dly = 8'h01;
  int req_cycles = 0;
  wire hreadyout, hresp, req, done;
  wire [31:0] hrdata, cfg_out;
  int num_errors = 0, num_checks = 0;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (req) req_cycles <= req_cycles + 1;
  obd_option_decoder i_dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .prog_mode(prog_mode), .part_64pin(part_64pin), .user_mem_erase_req(req),
    .user_mem_erase_done(done), .halt_entry_reset_en(cfg_out[31]),
    .watchdog_hw_en(cfg_out[30]), .reset_len_cycles(cfg_out[29:17]),
    .low_supply_detector_en(cfg_out[16]), .auxiliary_supply_detector_en(cfg_out[15]),
    .voltage_detect_sel(cfg_out[14:13]), .readout_protect_en(cfg_out[12]),
    .flash_write_block(cfg_out[11]), .package_sel_hi(cfg_out[10]),
    .unbonded_pad_pullup(cfg_out[9]), .osc_resonator_sel(cfg_out[8]), .osc_rc_sel(cfg_out[7]),
    .osc_external_sel(cfg_out[6]), .osc_reserved_sel(cfg_out[5]),
    .osc_freq_range_sel(cfg_out[4:2]), .osc_range_is_current(cfg_out[1]),
    .clock_doubler_en(cfg_out[0]));
  obd_mem_eraser i_eraser (.clk(hclk), .rst_n(hresetn), .req(req), .dly(erase_dly), .done(done));
  function automatic logic [31:0] exp_cfg(input logic [7:0] b0, b1, input logic p64);
    logic on;
    on = b0[4:3] != 2'h3;
    return {b0[7], ~b0[6], b1[6] ? 13'h0100 : 13'h1000, on, on, b0[4:3], ~b0[0], ~b0[0], b1[7],
      p64 ? ~b1[7] : 1'b1, b1[5:4] == 2'h0, b1[5:4] == 2'h2, b1[5:4] == 2'h3, b1[5:4] == 2'h1,
      b1[3:1], b1[5:4] == 2'h0, ~b1[0]};
  endfunction
  task automatic check(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic do_reset(input logic por);
    @(posedge hclk);
    hresetn <= 1'b0;
    por_n <= !por;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic t_access();
    ahb(`OBD_ADDR_OPT, 1'b1, 32'h0);
    ahb(`OBD_ADDR_OPT, 1'b0, 32'h0);
    check(rd, 32'h0);
    ahb(`OBD_ADDR_STAT, 1'b0, 32'h0);
    check(rd[2], 1'b0);
    check(rd[3], 1'b1);
    prog_mode <= 1'b1;
    ahb(`OBD_ADDR_OPT, 1'b0, 32'h0);
    check(rd, 32'h0000ffff);
    $display("Test access done");
  endtask
  task automatic t_erase();
    int base;
    for (int k = 0; k < 3; k++) begin
      do_reset(1'b1);
      erase_dly <= (k == 0) ? 8'h1e : 8'h01;
      base = req_cycles;
      ahb(`OBD_ADDR_OPT, 1'b1, {16'h0, 8'hff, (k < 2) ? 8'hfe : 8'hff});
      ahb(`OBD_ADDR_STAT, 1'b0, 32'h0);
      check(rd[1], k < 2);
      ahb(`OBD_ADDR_CMD, 1'b1, 32'h1);
      do ahb(`OBD_ADDR_STAT, 1'b0, 32'h0); while (rd[0] !== 1'b0);
      check(req_cycles != base, k < 2);
      ahb(`OBD_ADDR_OPT, 1'b0, 32'h0);
      check(rd, 32'h0000ffff);
    end
    $display("Test erase done");
  endtask
  task automatic t_config();
    logic [23:0] tbl [4];
    logic [31:0] exp;
    // Reserved byte0 bits 5 and 2 kept at one; bit1 varied
    tbl = '{24'hfe3f01, 24'h358200, 24'hefd701, 24'he66500};
    foreach (tbl[i]) begin
      do_reset(1'b1);
      @(posedge hclk);
      part_64pin <= tbl[i][0];
      ahb(`OBD_ADDR_OPT, 1'b1, {16'h0, tbl[i][15:8], tbl[i][23:16]});
      ahb(`OBD_ADDR_OPT, 1'b0, 32'h0);
      check(rd, {16'h0, tbl[i][15:8], tbl[i][23:16]});
      exp = exp_cfg(tbl[i][23:16], tbl[i][15:8], tbl[i][0]);
      do_reset(1'b0);
      check(cfg_out, exp);
      ahb(`OBD_ADDR_OPT, 1'b1, 32'h0);
      repeat (2) @(posedge hclk);
      #1;
      check(cfg_out, exp);
      ahb(`OBD_ADDR_CFG, 1'b0, 32'h0);
      check(rd, {13'h0, exp[0], exp[1], exp[4:2], exp[5], exp[6], exp[7], exp[8],
        exp[29:17] == 13'h1000, exp[9], exp[10], exp[12], exp[14:13], exp[15], exp[16],
        exp[30], exp[31]});
    end
    $display("Test config done");
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    check(cfg_out, exp_cfg(8'hff, 8'hff, 1'b1));
    $display("Test erased default done");
    t_access();
    t_erase();
    t_config();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    give_verdict();
  end
endmodule
